//--- hdl/dit_top.sv
// DMA interrupt, list-RAM EDC, error monitor and hardware trigger unit
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module dit_top
   import dit_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [JOBS-1:0] job_done,
   input wire logic [JOBS-1:0] job_finished_state,
   input wire logic [31:0] dest_addr,
   input wire logic dest_addr_valid,
   input wire logic master_error_resp,
   input wire logic [TRIG_W-1:0] hardware_job_trigger,
   input wire logic [1:0] serial_tx_half_empty,
   input wire logic [1:0] serial_tx_timer_expired,
   input wire logic [1:0] serial_tx_ack,
   input wire logic [REQ_W-1:0] hardware_transfer_request,
   output logic [JOBS-1:0] job_start_pulse,
   output logic [REQ_W-1:0] transfer_request,
   output logic transfer_irq,
   output logic memory_error_irq
);
   // Register state
   logic err_irq_en;
   logic [JOBS-1:0] job_irq_enable;
   logic [JOBS-1:0] job_done_irq_flags;
   logic [3:0] error_flags;
   logic [1:0] memory_error_event_register;
   logic check_bit_init_complete;
   logic [31:0] list_base;
   logic [31:0] list_len;
   logic [31:0] reg_base;
   logic [31:0] reg_len;
   logic [JOBS-1:0] hw_start_en;
   logic [1:0] delayed_tx_req;
   logic [TRIG_W-1:0] trig_q;

   // List RAM: transfer records then job stack, four 39-bit words per entry
   logic [CW_W-1:0] list_ram [RAM_WORDS];

   // AXI write channel latches
   logic aw_held, w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [11:0] wa;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wa = aw_addr;

   // Address/data taken in either order; one beat each held until response
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa < 12'h030 || wa >= OFS_RAM) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   logic full_word;
   assign full_word = (w_strb == 4'hf);

   // Error sources, each a one-cycle event
   logic [3:0] err_evt;
   logic [TRIG_W-1:0] trig_rise;
   logic [JOBS-1:0] retrig;
   logic dst_in_regs, dst_in_ram;
   assign trig_rise = hardware_job_trigger & ~trig_q;
   assign retrig = trig_rise[JOBS-1:0] & hw_start_en & ~job_finished_state;
   assign dst_in_regs = (dest_addr - reg_base) < reg_len;
   assign dst_in_ram = (dest_addr - list_base) < list_len;
   always_comb begin
      err_evt = '0;
      err_evt[ERR_DST] = dest_addr_valid && (dst_in_regs || dst_in_ram);
      err_evt[ERR_BUS] = master_error_resp;
      err_evt[ERR_RETRIG] = |retrig;
      err_evt[ERR_SLVWR] = do_write && !full_word;
   end

   // Trigger edge detect; inputs 0-31 start jobs (0-9 sync outputs, 10-15 timers), 32 and above reserved
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trig_q <= '0;
         job_start_pulse <= '0;
      end else begin
         trig_q <= hardware_job_trigger;
         job_start_pulse <= trig_rise[JOBS-1:0] & hw_start_en;
      end
   end

   // Delayed serial transmit requests, served as single-byte transfers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         delayed_tx_req <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (serial_tx_timer_expired[i] && serial_tx_half_empty[i]) begin
               delayed_tx_req[i] <= 1'b1;
            end else if (serial_tx_ack[i]) begin
               delayed_tx_req[i] <= 1'b0;
            end
         end
      end
   end

   // Request lines registered; delayed lines replace inputs 10 and 13
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         transfer_request <= '0;
      end else begin
         transfer_request <= hardware_transfer_request;
         transfer_request[10] <= delayed_tx_req[0];
         transfer_request[13] <= delayed_tx_req[1];
      end
   end

   // RAM access from the slave side only: core goes out over master and fabric
   logic ram_sel_w, ram_sel_r;
   logic [RAM_AW-1:0] ram_wa, ram_ra;
   logic [CHK_W-1:0] wr_chk;
   logic [CW_W-1:0] rd_word;
   logic [31:0] rd_fix;
   logic e1, e2;
   assign ram_sel_w = wa >= OFS_RAM;
   assign ram_wa = RAM_AW'(wa[10:2]);
   always_ff @(posedge clock) begin
      if (do_write && ram_sel_w && full_word) begin
         list_ram[ram_wa] <= {wr_chk, w_data};
      end
   end

   dit_edc u_edc (
      .wr_data(w_data),
      .wr_chk(wr_chk),
      .rd_word(rd_word),
      .rd_data(rd_fix),
      .err_single(e1),
      .err_double(e2)
   );

   // Read path: address taken, RAM read next cycle, answer the cycle after
   logic [1:0] rd_stage;
   logic [11:0] ar_addr;
   assign ram_sel_r = ar_addr >= OFS_RAM;
   assign ram_ra = RAM_AW'(ar_addr[10:2]);
   always_ff @(posedge clock) begin
      rd_word <= list_ram[ram_ra];
   end
   logic edc_evt_1b, edc_evt_2b;
   assign edc_evt_1b = rd_stage == 2'h2 && ram_sel_r && check_bit_init_complete && e1;
   assign edc_evt_2b = rd_stage == 2'h2 && ram_sel_r && check_bit_init_complete && e2;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_stage <= 2'h0;
         ar_addr <= 12'h000;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= rd_stage == 2'h0 && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            ar_addr <= s_axi_araddr;
            rd_stage <= 2'h1;
         end else if (rd_stage == 2'h1) begin
            rd_stage <= 2'h2;
         end else if (rd_stage == 2'h2) begin
            rd_stage <= 2'h3;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (ram_sel_r) begin
               s_axi_rdata <= rd_fix;
            end else if (ar_addr == OFS_CTRL) begin
               s_axi_rdata <= {31'h0, err_irq_en};
            end else if (ar_addr == OFS_IRQ_EN) begin
               s_axi_rdata <= job_irq_enable;
            end else if (ar_addr == OFS_JOB_FLAGS) begin
               s_axi_rdata <= job_done_irq_flags;
            end else if (ar_addr == OFS_ERR_FLAGS) begin
               s_axi_rdata <= {28'h0, error_flags};
            end else if (ar_addr == OFS_MEM_EVT) begin
               s_axi_rdata <= {30'h0, memory_error_event_register};
            end else if (ar_addr == OFS_INIT) begin
               s_axi_rdata <= {31'h0, check_bit_init_complete};
            end else if (ar_addr == OFS_LIST_BASE) begin
               s_axi_rdata <= list_base;
            end else if (ar_addr == OFS_LIST_LEN) begin
               s_axi_rdata <= list_len;
            end else if (ar_addr == OFS_REG_BASE) begin
               s_axi_rdata <= reg_base;
            end else if (ar_addr == OFS_REG_LEN) begin
               s_axi_rdata <= reg_len;
            end else if (ar_addr == OFS_HW_EN) begin
               s_axi_rdata <= hw_start_en;
            end else if (ar_addr == OFS_PENDING) begin
               s_axi_rdata <= {30'h0, delayed_tx_req};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_stage <= 2'h0;
         end
      end
   end

   // Control registers; init flag is software's promise that check bits are valid
   logic wr_ok;
   assign wr_ok = do_write && full_word;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         err_irq_en <= 1'b0;
         job_irq_enable <= '0;
         check_bit_init_complete <= 1'b0;
         list_base <= 32'h0000_0000;
         list_len <= LIST_LEN_RST;
         reg_base <= 32'h0000_0000;
         reg_len <= REG_LEN_RST;
         hw_start_en <= '0;
      end else if (wr_ok) begin
         if (wa == OFS_CTRL) err_irq_en <= w_data[CTRL_ERR_EN];
         if (wa == OFS_IRQ_EN) job_irq_enable <= w_data;
         if (wa == OFS_INIT) check_bit_init_complete <= w_data[0];
         if (wa == OFS_LIST_BASE) list_base <= w_data;
         if (wa == OFS_LIST_LEN) list_len <= w_data;
         if (wa == OFS_REG_BASE) reg_base <= w_data;
         if (wa == OFS_REG_LEN) reg_len <= w_data;
         if (wa == OFS_HW_EN) hw_start_en <= w_data;
      end
   end

   // Sticky flags: set wins over a clear in the same cycle (write-one; zero write for memory events)
   logic [JOBS-1:0] job_set;
   logic [3:0] err_set;
   assign job_set = job_done & job_irq_enable;
   assign err_set = err_evt & {4{err_irq_en}};
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         job_done_irq_flags <= '0;
         error_flags <= 4'h0;
         memory_error_event_register <= 2'h0;
      end else begin
         job_done_irq_flags <= (job_done_irq_flags
            & ~((wr_ok && wa == OFS_JOB_FLAGS) ? w_data : 32'h0)) | job_set;
         error_flags <= (error_flags
            & ~((wr_ok && wa == OFS_ERR_FLAGS) ? w_data[3:0] : 4'h0)) | err_set;
         memory_error_event_register <= ((wr_ok && wa == OFS_MEM_EVT && w_data == 32'h0)
            ? 2'h0 : memory_error_event_register) | {edc_evt_2b, edc_evt_1b};
      end
   end

   // One combined pulse when job-done and error coincide
   dit_pulse u_xfer_irq (
      .clock(clock),
      .rst_n(rst_n),
      .fire(|job_set || |err_set),
      .irq(transfer_irq)
   );
   dit_pulse u_mem_irq (
      .clock(clock),
      .rst_n(rst_n),
      .fire(edc_evt_1b || edc_evt_2b),
      .irq(memory_error_irq)
   );

   job_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      |job_set |=> (job_done_irq_flags & $past(job_set)) == $past(job_set))
      else $error("job flag not set");
   irq_after_job_a: assert property (@(posedge clock) disable iff (!rst_n)
      |job_set |-> ##[1:2] transfer_irq)
      else $error("no transfer irq");
   err_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      err_set[ERR_BUS] |=> error_flags[ERR_BUS])
      else $error("bus error not flagged");
   err_gated_a: assert property (@(posedge clock) disable iff (!rst_n)
      !err_irq_en && error_flags == 4'h0 |=> error_flags == 4'h0)
      else $error("error flag without enable");
   slave_size_a: assert property (@(posedge clock) disable iff (!rst_n)
      do_write && !full_word && err_irq_en |=> error_flags[ERR_SLVWR])
      else $error("slave size error missed");
   mem_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      wr_ok && wa == OFS_MEM_EVT && w_data == 32'h0 && !edc_evt_1b && !edc_evt_2b
      |=> memory_error_event_register == 2'h0)
      else $error("memory event not cleared");
   trig_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
      |job_start_pulse |-> (job_start_pulse
      & ~$past(hardware_job_trigger[JOBS-1:0] & ~trig_q[JOBS-1:0])) == '0)
      else $error("start without rising edge");
   delayed_req_a: assert property (@(posedge clock) disable iff (!rst_n)
      serial_tx_timer_expired[0] && serial_tx_half_empty[0] |=> ##1 transfer_request[10])
      else $error("delayed request missing");
endmodule
`default_nettype wire

//--- hdl/dit_pkg.sv
// Package with constants and register map of the DMA irq/EDC/trigger unit
package dit_pkg;
   localparam int RECORDS = 256;
   localparam int STACKS = 32;
   localparam int RAM_WORDS = (RECORDS + STACKS) * 4;
   localparam int RAM_AW = 11;
   localparam int CHK_W = 7;
   localparam int CW_W = 32 + CHK_W;
   localparam int JOBS = 32;
   localparam int TRIG_W = 64;
   localparam int REQ_W = 32;
   localparam int IRQ_CYCLES = 3;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_IRQ_EN = 12'h004;
   localparam logic [11:0] OFS_JOB_FLAGS = 12'h008;
   localparam logic [11:0] OFS_ERR_FLAGS = 12'h00c;
   localparam logic [11:0] OFS_MEM_EVT = 12'h010;
   localparam logic [11:0] OFS_INIT = 12'h014;
   localparam logic [11:0] OFS_LIST_BASE = 12'h018;
   localparam logic [11:0] OFS_LIST_LEN = 12'h01c;
   localparam logic [11:0] OFS_REG_BASE = 12'h020;
   localparam logic [11:0] OFS_REG_LEN = 12'h024;
   localparam logic [11:0] OFS_HW_EN = 12'h028;
   localparam logic [11:0] OFS_PENDING = 12'h02c;
   localparam logic [11:0] OFS_RAM = 12'h800;
   // Field positions and window length reset values
   localparam int CTRL_ERR_EN = 0;
   localparam int ERR_DST = 0;
   localparam int ERR_BUS = 1;
   localparam int ERR_RETRIG = 2;
   localparam int ERR_SLVWR = 3;
   localparam int EVT_1B = 0;
   localparam int EVT_2B = 1;
   localparam logic [31:0] LIST_LEN_RST = 32'h0000_1200;
   localparam logic [31:0] REG_LEN_RST = 32'h0000_1000;
endpackage

//--- hdl/dit_edc.sv
// Hamming SEC-DED encoder and decoder for 32-bit words with 7 check bits
`timescale 1ns/1ns
`default_nettype none
module dit_edc
   import dit_pkg::*;
(
   input wire logic [31:0] wr_data,
   output logic [CHK_W-1:0] wr_chk,
   input wire logic [CW_W-1:0] rd_word,
   output logic [31:0] rd_data,
   output logic err_single,
   output logic err_double
);
   // Code of data bit i: two or more ones, so no single check-bit flip aliases a data bit
   function automatic logic [5:0] code_of(input int i);
      return (i < 31) ? 6'(i + 33) : 6'h03;
   endfunction
   // Six parity groups: each set data bit folds its own code into the syndrome
   function automatic logic [5:0] syn_of(input logic [31:0] d);
      logic [5:0] s;
      s = '0;
      for (int i = 0; i < 32; i++) begin
         if (d[i]) begin
            s = s ^ code_of(i);
         end
      end
      return s;
   endfunction

   logic [5:0] syn;
   logic par;
   logic [5:0] stored;
   // Encode: group parity plus overall parity over data and groups
   always_comb begin
      wr_chk[5:0] = syn_of(wr_data);
      wr_chk[6] = ^{wr_data, syn_of(wr_data)};
   end
   // Decode: nonzero syndrome locates a data bit or a check bit; parity splits 1b from 2b
   always_comb begin
      stored = rd_word[37:32];
      syn = syn_of(rd_word[31:0]) ^ stored;
      par = ^rd_word;
      rd_data = rd_word[31:0];
      err_single = 1'b0;
      err_double = 1'b0;
      if (syn != 6'h00 && !par) begin
         err_double = 1'b1;
      end else if (par) begin
         err_single = 1'b1;
         for (int i = 0; i < 32; i++) begin
            if (syn == code_of(i)) begin
               rd_data[i] = ~rd_word[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- hdl/dit_pulse.sv
// Fixed-length interrupt pulse stretcher
`timescale 1ns/1ns
`default_nettype none
module dit_pulse
   import dit_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic fire,
   output logic irq
);
   logic [2:0] cnt;
   logic pend;
   // Events during a running pulse wait for it to end: all of them merge into one later pulse and
   // a burst of events never stretches one pulse past its upper limit
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 3'h0;
         irq <= 1'b0;
         pend <= 1'b0;
      end else if (!irq && (fire || pend)) begin
         cnt <= 3'(IRQ_CYCLES - 1);
         irq <= 1'b1;
         pend <= 1'b0;
      end else if (irq) begin
         if (fire) begin
            pend <= 1'b1;
         end
         if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
         end else begin
            irq <= 1'b0;
         end
      end
   end

   irq_width_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(irq) |-> irq [*3] ##1 !irq)
      else $error("irq pulse not 3 cycles");
endmodule
`default_nettype wire

//--- testbench/dit_periph_model.sv
// Behavioural model of the serial peripherals and timers feeding the unit
`timescale 1ns/1ns
`default_nettype none
module dit_periph_model (
   input wire logic clock,
   output logic [1:0] serial_tx_half_empty,
   output logic [1:0] serial_tx_timer_expired,
   output logic [31:0] hardware_transfer_request
);
   // Quiet at time zero: no FIFO asks for service until told to
   initial begin
      serial_tx_half_empty = '0;
      serial_tx_timer_expired = '0;
      hardware_transfer_request = '0;
   end

   // FIFO levels change just after an edge and stay as long as the FIFO state lasts
   task automatic set_levels(input logic [1:0] he, input logic [31:0] req);
      @(posedge clock);
      serial_tx_half_empty <= he;
      hardware_transfer_request <= req;
   endtask

   // Timer expiry is a one-cycle strobe, whatever the FIFO level is
   task automatic expire(input int ch);
      @(posedge clock);
      serial_tx_timer_expired[ch] <= 1'b1;
      @(posedge clock);
      serial_tx_timer_expired[ch] <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- testbench/dma_irq_edc_trigger_unit_tb_top.sv
// Self-checking bench for the DMA irq, list-RAM EDC, error and trigger unit
`timescale 1ns/1ns
`default_nettype none
module dma_irq_edc_trigger_unit_tb_top;
   import dit_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd, dest = '0, fin = '1, job_done = '0, jsp, treq, seen;
   logic [3:0] wstrb = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, dest_v = 0, merr = 0;
   logic awready, wready, bvalid, arready, rvalid, tirq, mirq;
   logic [1:0] bresp, rresp, br, rr, he, tmo, tx_ack = '0;
   logic [63:0] trig = '0;
   logic [31:0] req;
   int n_fail = 0, num_checks = 0, cyc = 0, hi, ups;
   logic [31:0] dl [4] = '{32'h3000_0000, 32'h4000_0ffc, 32'h1000_11fc, 32'h1000_1200};
   logic [31:0] de [4] = '{32'h0, 32'h1, 32'h1, 32'h0};

   dit_top i_dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .job_done(job_done), .job_finished_state(fin), .dest_addr(dest), .dest_addr_valid(dest_v),
      .master_error_resp(merr), .hardware_job_trigger(trig), .serial_tx_half_empty(he),
      .serial_tx_timer_expired(tmo), .serial_tx_ack(tx_ack), .hardware_transfer_request(req),
      .job_start_pulse(jsp), .transfer_request(treq), .transfer_irq(tirq),
      .memory_error_irq(mirq));
   dit_periph_model i_model (.clock(clock), .serial_tx_half_empty(he),
      .serial_tx_timer_expired(tmo), .hardware_transfer_request(req));

   // 50 MHz clock
   always #10 clock = ~clock;

   // Cut a hang short well above the few hundred cycles the tests need
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Address and data go out together; each is dropped at the edge that takes it
   task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (!ad && awready === 1'b1) awvalid <= 1'b0;
         if (awready === 1'b1) ad = 1'b1;
         if (!wd && wready === 1'b1) wvalid <= 1'b0;
         if (wready === 1'b1) wd = 1'b1;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axw(a, d, 4'hf, br);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
      axr(a, rd, rr);
      chk(nm, e, rd);
   endtask

   // One-cycle event strobes, then count irq cycles and rising edges in a window
   task automatic fire(input logic [31:0] j, input logic m, input logic dv);
      logic p;
      p = 1'b0;
      hi = 0;
      ups = 0;
      @(posedge clock);
      job_done <= j;
      merr <= m;
      dest_v <= dv;
      @(posedge clock);
      job_done <= '0;
      merr <= 1'b0;
      dest_v <= 1'b0;
      repeat (12) begin
         @(posedge clock);
         if (tirq === 1'b1) hi++;
         if (tirq === 1'b1 && !p) ups++;
         p = (tirq === 1'b1);
      end
   endtask

   // Raise one trigger line and count cycles with any job start strobe
   task automatic trig_up(input int b);
      hi = 0;
      seen = '0;
      @(posedge clock);
      trig[b] <= 1'b1;
      repeat (6) begin
         @(posedge clock);
         if (jsp !== '0) hi++;
         if (jsp !== '0) seen = jsp;
      end
      trig[b] <= 1'b0;
   endtask

   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      rdc(OFS_LIST_LEN, LIST_LEN_RST, "list_len");
      rdc(OFS_REG_LEN, REG_LEN_RST, "reg_len");
      axr(12'h7f0, rd, rr);
      chk("unmapped_rresp", 32'h2, {30'h0, rr});
      axw(12'h7f0, 32'h1, 4'hf, br);
      chk("unmapped_bresp", 32'h2, {30'h0, br});
      // First and last reachable list RAM words keep their data
      wr(OFS_RAM, 32'hdead_beef);
      wr(OFS_RAM + 12'h7fc, 32'h1234_5678);
      rdc(OFS_RAM, 32'hdead_beef, "ram_first");
      rdc(OFS_RAM + 12'h7fc, 32'h1234_5678, "ram_last");
      wr(OFS_INIT, 32'h1);
      // Clean word read with check bits trusted raises no memory error
      rdc(OFS_RAM, 32'hdead_beef, "ram_clean_read");
      chk("mem_irq_clean", 32'h0, {31'h0, mirq});
      wr(OFS_MEM_EVT, 32'h0);
      rdc(OFS_MEM_EVT, 32'h0, "mem_evt");
      // Job 5 enabled, job 6 not: one pulse and one flag
      wr(OFS_IRQ_EN, 32'h20);
      fire(32'h60, 1'b0, 1'b0);
      chk("irq_len", IRQ_CYCLES, hi);
      chk("irq_pulses", 1, ups);
      rdc(OFS_JOB_FLAGS, 32'h20, "job_flags");
      wr(OFS_JOB_FLAGS, 32'h40);
      rdc(OFS_JOB_FLAGS, 32'h20, "job_flags_kept");
      wr(OFS_JOB_FLAGS, 32'h20);
      rdc(OFS_JOB_FLAGS, 32'h0, "job_flags_clr");
      // Bus error with the global enable off, then on
      wr(OFS_CTRL, 32'h0);
      fire(32'h0, 1'b1, 1'b0);
      chk("irq_err_off", 0, hi);
      rdc(OFS_ERR_FLAGS, 32'h0, "err_off");
      wr(OFS_CTRL, 32'h1);
      fire(32'h0, 1'b1, 1'b0);
      chk("irq_err_on", IRQ_CYCLES, hi);
      rdc(OFS_ERR_FLAGS, 32'h2, "err_bus");
      wr(OFS_ERR_FLAGS, 32'h2);
      rdc(OFS_ERR_FLAGS, 32'h0, "err_clr");
      // Destinations near the top edge of the register and list windows, and one between the two windows
      wr(OFS_REG_BASE, 32'h4000_0000);
      wr(OFS_LIST_BASE, 32'h1000_0000);
      for (int i = 0; i < 4; i++) begin
         dest <= dl[i];
         fire(32'h0, 1'b0, 1'b1);
         rdc(OFS_ERR_FLAGS, de[i], "err_dst");
         wr(OFS_ERR_FLAGS, 32'h1);
      end
      // Half-word write is ignored but answered OKAY
      axw(OFS_IRQ_EN, 32'hffff, 4'h3, br);
      chk("bresp_half", 32'h0, {30'h0, br});
      rdc(OFS_IRQ_EN, 32'h20, "irq_en_kept");
      rdc(OFS_ERR_FLAGS, 32'h8, "err_slvwr");
      wr(OFS_ERR_FLAGS, 32'h8);
      // Timer-fed trigger starts its job once; a reserved line does nothing
      wr(OFS_HW_EN, 32'h1004);
      trig_up(12);
      chk("start_len", 1, hi);
      chk("start_job", 32'h1000, seen);
      trig_up(40);
      chk("reserved_trig", 0, hi);
      fin <= ~32'h4;
      trig_up(2);
      rdc(OFS_ERR_FLAGS, 32'h4, "err_retrig");
      // Last job: started by its trigger, then disabled so a new edge is ignored
      wr(OFS_HW_EN, 32'h8000_0000);
      trig_up(31);
      chk("last_job_start", 32'h8000_0000, seen);
      wr(OFS_HW_EN, 32'h0);
      trig_up(31);
      chk("last_job_off", 0, hi);
      // Request levels pass through; delayed tx request set by timer, cleared by ack
      i_model.set_levels(2'b01, 32'h0000_0203);
      repeat (3) @(posedge clock);
      chk("treq_levels", 32'h0000_0203, treq);
      i_model.expire(0);
      repeat (6) @(posedge clock);
      chk("treq_delayed", 32'h0000_0603, treq);
      tx_ack <= 2'b01;
      @(posedge clock);
      tx_ack <= 2'b00;
      repeat (3) @(posedge clock);
      chk("treq_acked", 32'h0000_0203, treq);
      i_model.expire(1);
      repeat (3) @(posedge clock);
      chk("treq_not_half", 32'h0000_0203, treq);
      // Job end and error in one cycle give one combined pulse
      wr(OFS_ERR_FLAGS, 32'hf);
      fire(32'h20, 1'b1, 1'b0);
      chk("irq_comb_len", IRQ_CYCLES, hi);
      chk("irq_comb_pulses", 1, ups);
      rdc(OFS_JOB_FLAGS, 32'h20, "comb_job");
      rdc(OFS_ERR_FLAGS, 32'h2, "comb_err");
      print_verdict();
   end
endmodule
`default_nettype wire
